/* dual_port_ram.sv */
// two-port synchronous ram with apb control of read-during-write behaviour
`default_nettype none
module dual_port_ram #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [rdw_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rdw_pkg::APB_DW-1:0] pwdata,
  output logic [rdw_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // port a
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [DATA_W-1:0] wdata_a,
  input wire logic we_a,
  input wire logic [DATA_W/rdw_pkg::BYTE_W-1:0] be_a,
  output logic [DATA_W-1:0] q_a,
  // port b
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic [DATA_W-1:0] wdata_b,
  input wire logic we_b,
  input wire logic [DATA_W/rdw_pkg::BYTE_W-1:0] be_b,
  output logic [DATA_W-1:0] q_b
);
  import rdw_pkg::*;
  localparam int NB = DATA_W / BYTE_W;
  localparam int DEPTH = 1 << ADDR_W;

  if (DATA_W % BYTE_W != 0 || DATA_W > APB_DW || ADDR_W < 1 || ADDR_W > 12) begin : g_bad
    $error("dual_port_ram: unsupported DATA_W or ADDR_W");
  end

  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic coll_r, coll_nxt;
  logic [ADDR_W-1:0] load_addr_r, load_addr_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [APB_DW-1:0] prdata_r, prdata_nxt;
  logic [DATA_W-1:0] q_a_r, q_a_nxt;
  logic [DATA_W-1:0] q_b_r, q_b_nxt;
  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [DATA_W-1:0] mem_nxt [DEPTH];

  logic [DATA_W-1:0] old_a, old_b, new_a, new_b, load_word;
  logic simple, we_b_eff, hit, collision;
  logic apb_access, apb_done;
  logic sel_ctrl, sel_stat, sel_ladr, sel_ldat, mapped;
  logic [APB_DW-1:0] rd_mux;

  assign simple = ctrl_r[CTRL_SIMPLE];
  // in simple dual mode port b only reads
  assign we_b_eff = we_b && !simple;
  assign hit = (addr_a == addr_b);
  assign old_a = mem_r[addr_a];
  assign old_b = mem_r[addr_b];
  assign load_word = mem_r[load_addr_r];
  // only flagged when the client promised never to collide
  assign collision = ctrl_r[CTRL_NO_TIMING] && hit && (we_a || we_b_eff);

  // byte-enable merge of write data over the stored word
  for (genvar i = 0; i < NB; i++) begin : g_merge
    assign new_a[i*BYTE_W +: BYTE_W] = be_a[i] ? wdata_a[i*BYTE_W +: BYTE_W]
                                               : old_a[i*BYTE_W +: BYTE_W];
    assign new_b[i*BYTE_W +: BYTE_W] = be_b[i] ? wdata_b[i*BYTE_W +: BYTE_W]
                                               : old_b[i*BYTE_W +: BYTE_W];
  end

  rdw_port_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) ifa ();
  rdw_port_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) ifb ();

  assign ifa.we = we_a;
  assign ifa.other_we = we_b_eff;
  assign ifa.own_addr = addr_a;
  assign ifa.other_addr = addr_b;
  assign ifa.be = be_a;
  assign ifa.old_word = old_a;
  assign ifa.own_new = new_a;
  assign ifa.other_new = new_b;
  assign ifa.same_new = ctrl_r[CTRL_A_NEW];
  assign ifa.mixed_old = ctrl_r[CTRL_MIXED_OLD];
  assign ifa.dist_mem = ctrl_r[CTRL_DIST_MEM];
  assign ifa.mask_x = ctrl_r[CTRL_MASK_X];

  assign ifb.we = we_b_eff;
  assign ifb.other_we = we_a;
  assign ifb.own_addr = addr_b;
  assign ifb.other_addr = addr_a;
  assign ifb.be = be_b;
  assign ifb.old_word = old_b;
  assign ifb.own_new = new_b;
  assign ifb.other_new = new_a;
  assign ifb.same_new = ctrl_r[CTRL_B_NEW];
  assign ifb.mixed_old = ctrl_r[CTRL_MIXED_OLD];
  assign ifb.dist_mem = ctrl_r[CTRL_DIST_MEM];
  assign ifb.mask_x = ctrl_r[CTRL_MASK_X];

  rdw_out_sel u_sel_a (
    .p(ifa.sel)
  );
  rdw_out_sel u_sel_b (
    .p(ifb.sel)
  );

  // apb decode; one wait state keeps pready registered
  assign apb_access = psel && penable && !pready_r;
  assign apb_done = psel && penable && pready_r;
  assign sel_ctrl = (paddr == OFS_CTRL);
  assign sel_stat = (paddr == OFS_STATUS);
  assign sel_ladr = (paddr == OFS_LOAD_ADDR);
  assign sel_ldat = (paddr == OFS_LOAD_DATA);
  assign mapped = sel_ctrl || sel_stat || sel_ladr || sel_ldat;
  assign rd_mux = sel_ctrl ? APB_DW'(ctrl_r) :
                  sel_stat ? APB_DW'(coll_r) << STAT_COLL :
                  sel_ladr ? APB_DW'(load_addr_r) :
                  sel_ldat ? APB_DW'(load_word) : '0;

  always_comb begin
    ctrl_nxt = ctrl_r;
    coll_nxt = coll_r;
    load_addr_nxt = load_addr_r;
    mem_nxt = mem_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    // port a is write-only in simple dual mode
    q_a_nxt = simple ? '0 : ifa.rd_word;
    q_b_nxt = ifb.rd_word;
    if (we_a) begin
      mem_nxt[addr_a] = new_a;
    end
    // on a double write to one word port b lands last
    if (we_b_eff) begin
      mem_nxt[addr_b] = new_b;
    end
    if (apb_access) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt = pwrite ? '0 : rd_mux;
    end
    if (apb_done && pwrite) begin
      if (sel_ctrl) begin
        ctrl_nxt = pwdata[CTRL_W-1:0];
      end
      if (sel_stat && pwdata[STAT_COLL]) begin
        coll_nxt = 1'b0;
      end
      if (sel_ladr) begin
        load_addr_nxt = pwdata[ADDR_W-1:0];
      end
      if (sel_ldat) begin
        // loader streams initial content, address steps itself
        mem_nxt[load_addr_r] = pwdata[DATA_W-1:0];
        load_addr_nxt = load_addr_r + ADDR_W'(1);
      end
    end
    // a new collision beats a same-cycle clear
    if (collision) begin
      coll_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      coll_r <= 1'b0;
      load_addr_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      q_a_r <= '0;
      q_b_r <= '0;
      mem_r <= '{default: '0};
    end else begin
      ctrl_r <= ctrl_nxt;
      coll_r <= coll_nxt;
      load_addr_r <= load_addr_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      q_a_r <= q_a_nxt;
      q_b_r <= q_b_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign q_a = q_a_r;
  assign q_b = q_b_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mixed_old_b: assert property (
    (ctrl_r[CTRL_MIXED_OLD] && we_a && !we_b_eff && hit) |=> (q_b_r == $past(old_b))
  ) else $error("mixed old read did not return prior word");
  a_dist_defined: assert property (
    (!ctrl_r[CTRL_MIXED_OLD] && ctrl_r[CTRL_DIST_MEM] && we_a && !we_b_eff && hit)
      |=> (q_b_r == $past(new_a))
  ) else $error("distributed dont-care read not the written word");
  a_same_new_a: assert property (
    (!simple && we_a && ctrl_r[CTRL_A_NEW] && (&be_a)) |=> (q_a_r == $past(wdata_a))
  ) else $error("new data not shown on writing port");
  a_same_old_b: assert property (
    (we_b_eff && !ctrl_r[CTRL_B_NEW]) |=> (q_b_r == $past(old_b))
  ) else $error("old data not shown on writing port");
  a_mask_off_old: assert property (
    (!simple && we_a && ctrl_r[CTRL_A_NEW] && !ctrl_r[CTRL_MASK_X])
      |=> (q_a_r == $past(new_a))
  ) else $error("masked bytes lost old contents with option off");
  a_reset_zero: assert property (
    $rose(presetn) |-> (mem_r[0] == '0 && mem_r[DEPTH-1] == '0 && q_a_r == '0)
  ) else $error("memory not zero after reset");
  a_load_lands: assert property (
    (apb_done && pwrite && sel_ldat && !we_a && !we_b_eff)
      |=> (mem_r[$past(load_addr_r)] == $past(pwdata[DATA_W-1:0]))
        && (load_addr_r == $past(load_addr_r) + ADDR_W'(1))
  ) else $error("loaded word not stored");
  a_plain_read_b: assert property (
    (!we_b_eff && !(we_a && hit)) |=> (q_b_r == $past(old_b))
  ) else $error("uncontested read wrong");
  a_coll_sticky: assert property (
    collision |=> coll_r ##1
      (coll_r || $past(apb_done && pwrite && sel_stat && pwdata[STAT_COLL]))
  ) else $error("collision flag not set or not sticky");
  a_apb_wait: assert property (
    apb_access |=> pready_r ##1 !pready_r
  ) else $error("apb answer timing wrong");

  c_mixed_collision: cover property (we_a && hit && !we_b_eff ##1 1'b1);
  c_new_data_write: cover property (we_a && ctrl_r[CTRL_A_NEW] && !simple);
  c_load_write: cover property (apb_done && pwrite && sel_ldat);
  c_simple_read: cover property (simple && we_a && hit);
endmodule : dual_port_ram
`default_nettype wire

/* rdw_pkg.sv */
// shared constants for the two-port ram with selectable read-during-write behaviour
`default_nettype none
package rdw_pkg;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int BYTE_W = 8;
  // register byte addresses
  localparam logic [APB_AW-1:0] OFS_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] OFS_LOAD_ADDR = 12'h008;
  localparam logic [APB_AW-1:0] OFS_LOAD_DATA = 12'h00C;
  // control field positions
  localparam int CTRL_W = 7;
  localparam int CTRL_MIXED_OLD = 0;
  localparam int CTRL_DIST_MEM = 1;
  localparam int CTRL_NO_TIMING = 2;
  localparam int CTRL_A_NEW = 3;
  localparam int CTRL_B_NEW = 4;
  localparam int CTRL_MASK_X = 5;
  localparam int CTRL_SIMPLE = 6;
  // mixed old, both ports new data, true dual port
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h19;
  // status field positions
  localparam int STAT_COLL = 0;
endpackage : rdw_pkg
`default_nettype wire

/* rdw_port_if.sv */
// per-port signals between the ram core and its output selector
`default_nettype none
interface rdw_port_if #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 4
);
  logic we;
  logic other_we;
  logic [ADDR_W-1:0] own_addr;
  logic [ADDR_W-1:0] other_addr;
  logic [DATA_W/rdw_pkg::BYTE_W-1:0] be;
  logic [DATA_W-1:0] old_word;
  logic [DATA_W-1:0] own_new;
  logic [DATA_W-1:0] other_new;
  logic same_new;
  logic mixed_old;
  logic dist_mem;
  logic mask_x;
  logic [DATA_W-1:0] rd_word;
  modport drv (
    output we, other_we, own_addr, other_addr, be, old_word, own_new, other_new,
    output same_new, mixed_old, dist_mem, mask_x,
    input rd_word
  );
  modport sel (
    input we, other_we, own_addr, other_addr, be, old_word, own_new, other_new,
    input same_new, mixed_old, dist_mem, mask_x,
    output rd_word
  );
endinterface : rdw_port_if
`default_nettype wire

/* rdw_out_sel.sv */
// read word selection for one port during same-port and mixed-port collisions
`default_nettype none
module rdw_out_sel (
  // port view
  rdw_port_if.sel p
);
  import rdw_pkg::*;
  localparam int NB = $bits(p.be);
  logic mixed_hit;
  assign mixed_hit = p.other_we && (p.other_addr == p.own_addr);
  for (genvar i = 0; i < NB; i++) begin : g_lane
    // one driver per lane slice keeps the read word single-sourced
    logic [BYTE_W-1:0] lane_word;
    always_comb begin
      lane_word = p.old_word[i*BYTE_W +: BYTE_W];
      if (p.we) begin
        if (p.same_new) begin
          lane_word = p.own_new[i*BYTE_W +: BYTE_W];
          if (p.mask_x && !p.be[i]) begin
            lane_word = 'X;
          end
        end
        // old data keeps the pre-write word
      end else if (mixed_hit && !p.mixed_old) begin
        if (p.dist_mem) begin
          // timed path: a defined word, never metastable
          lane_word = p.other_new[i*BYTE_W +: BYTE_W];
        end else begin
          lane_word = 'X;
        end
      end
      // mixed old leaves the pre-write word
    end
    assign p.rd_word[i*BYTE_W +: BYTE_W] = lane_word;
  end
endmodule : rdw_out_sel
`default_nettype wire

/* mem_client.sv */
// client logic model that drives both memory ports
`default_nettype none
module mem_client (
  // clock
  input wire logic pclk,
  // port a
  output logic [3:0] addr_a,
  output logic [31:0] wdata_a,
  output logic we_a,
  output logic [3:0] be_a,
  // port b
  output logic [3:0] addr_b,
  output logic [31:0] wdata_b,
  output logic we_b,
  output logic [3:0] be_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {addr_a, wdata_a, we_a, be_a, addr_b, wdata_b, we_b, be_b} = '0;
  end
  // one access on both ports, w = {we_a, we_b}; returns just after the write edge
  task automatic go(input logic [3:0] aa, ab, input logic [1:0] w, input logic [3:0] ba,
                    input logic [31:0] da, db);
    @(posedge pclk);
    {addr_a, addr_b, we_a, we_b, be_a} <= {aa, ab, w, ba};
    wdata_a <= da;
    wdata_b <= db;
    be_b <= 4'hF;
    @(posedge pclk);
    {we_a, we_b} <= 2'b00;
    // released data must not keep showing the last word
    wdata_a <= ~da;
    wdata_b <= ~db;
    #1;
  endtask : go
endmodule : mem_client
`default_nettype wire

/* dual_port_ram_rdw_behavior_tb.sv */
// self-checking bench for the two-port ram read-during-write choices
`default_nettype none
module dual_port_ram_rdw_behavior_tb;
  import rdw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [APB_DW-1:0] prdata, rd;
  logic pready, pslverr, err;
  logic [3:0] addr_a, addr_b, be_a, be_b;
  logic [31:0] wdata_a, wdata_b, q_a, q_b;
  logic we_a, we_b;
  int n_errors = 0;
  int n_tests = 0;
  always #20 pclk = ~pclk;
  dual_port_ram #(.ADDR_W(4), .DATA_W(32)) dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .addr_a, .wdata_a, .we_a, .be_a, .q_a, .addr_b, .wdata_b, .we_b, .be_b, .q_b
  );
  mem_client cli (
    .pclk, .addr_a, .wdata_a, .we_a, .be_a, .addr_b, .wdata_b, .we_b, .be_b
  );
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // the master waits on pready with no assumed latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic t_reset;
    chk(q_a, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, {25'h0, CTRL_RST});
    apb(1'b0, OFS_LOAD_DATA, 32'h0);
    chk(rd, 32'h0);
    cli.go(4'h7, 4'hE, 2'b00, 4'hF, 32'h0, 32'h0);
    chk(q_b, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask : t_reset
  task automatic t_init;
    apb(1'b1, OFS_LOAD_ADDR, 32'h5);
    apb(1'b1, OFS_LOAD_DATA, 32'hA5A5_0001);
    apb(1'b1, OFS_LOAD_DATA, 32'hA5A5_0002);
    apb(1'b0, OFS_LOAD_ADDR, 32'h0);
    chk(rd, 32'h7);
    cli.go(4'h5, 4'h6, 2'b00, 4'hF, 32'h0, 32'h0);
    chk(q_a, 32'hA5A5_0001);
    chk(q_b, 32'hA5A5_0002);
  endtask : t_init
  task automatic t_same;
    cli.go(4'h5, 4'h5, 2'b10, 4'hF, 32'h1111_2222, 32'h0);
    chk(q_a, 32'h1111_2222);
    chk(q_b, 32'hA5A5_0001);
    cli.go(4'h0, 4'h5, 2'b00, 4'hF, 32'h0, 32'h0);
    chk(q_b, 32'h1111_2222);
  endtask : t_same
  task automatic t_old;
    apb(1'b1, OFS_CTRL, 32'h11);
    cli.go(4'h6, 4'h9, 2'b11, 4'hF, 32'hCAFE_0006, 32'h0BAD_0009);
    chk(q_a, 32'hA5A5_0002);
    chk(q_b, 32'h0BAD_0009);
    // port b in old mode, port a reads the same word
    apb(1'b1, OFS_CTRL, 32'h09);
    cli.go(4'h9, 4'h9, 2'b01, 4'hF, 32'h0, 32'h0000_9999);
    chk(q_b, 32'h0BAD_0009);
    chk(q_a, 32'h0BAD_0009);
  endtask : t_old
  task automatic t_mask;
    apb(1'b1, OFS_CTRL, 32'h29);
    cli.go(4'h6, 4'h0, 2'b10, 4'h1, 32'h1234_5678, 32'h0);
    chk(q_a, 32'hXXXX_XX78);
    cli.go(4'h6, 4'h0, 2'b00, 4'hF, 32'h0, 32'h0);
    chk(q_a, 32'hCAFE_0078);
  endtask : t_mask
  task automatic t_dont_care;
    apb(1'b1, OFS_CTRL, 32'h1A);
    cli.go(4'h3, 4'h3, 2'b10, 4'hF, 32'h3333_0003, 32'h0);
    chk(q_b, 32'h3333_0003);
    apb(1'b1, OFS_CTRL, 32'h18);
    cli.go(4'h3, 4'h3, 2'b10, 4'hF, 32'h4444_0004, 32'h0);
    chk(q_b, 32'hXXXX_XXXX);
  endtask : t_dont_care
  task automatic t_coll;
    apb(1'b1, OFS_CTRL, 32'h1D);
    cli.go(4'h2, 4'h7, 2'b10, 4'hF, 32'h0, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    // deliberate collision so the flag can be seen
    cli.go(4'h2, 4'h2, 2'b10, 4'hF, 32'h5, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask : t_coll
  task automatic t_simple;
    // one write port a, one read port b: a write on b must be ignored
    apb(1'b1, OFS_CTRL, 32'h59);
    cli.go(4'h8, 4'h8, 2'b11, 4'hF, 32'h8888_0008, 32'h0BAD_0008);
    chk(q_a, 32'h0);
    chk(q_b, 32'h0);
    cli.go(4'h0, 4'h8, 2'b00, 4'hF, 32'h0, 32'h0);
    chk(q_b, 32'h8888_0008);
  endtask : t_simple
  initial begin
    #200us;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_init();
    t_same();
    t_old();
    t_mask();
    t_dont_care();
    t_coll();
    t_simple();
    end_sim();
  end
endmodule : dual_port_ram_rdw_behavior_tb
`default_nettype wire
